// File: core/settings_preserve.sv
`timescale 1ns/1ps
module settings_preserve
  import settings_pkg::*;
#(
  parameter bit HAS_PRESERVE = 1'b1,  // preservation supported
  parameter bit HAS_QUEUE_LOG = 1'b1, // log page 10h supported
  parameter bit HAS_EVENT_LOG = 1'b1, // log page 11h supported
  parameter bit HAS_SECURITY = 1'b1,  // security feature set
  parameter bit HAS_APM      = 1'b1,  // advanced power management
  parameter bit HAS_STREAM   = 1'b1   // stream error logs
) (
  input  wire logic                   clk_sys,        // 20 MHz clock
  input  wire logic                   rst,            // power-up reset
  input  wire logic                   soft_reset,     // software reset pulse
  input  wire logic                   link_reset,     // link reset pulse
  input  wire logic                   cmd_valid,      // command pulse
  input  wire settings_pkg::host_cmd_t cmd,           // command contents
  input  wire logic                   rd_err_log,     // read stream error event
  input  wire logic                   wr_err_log,     // write stream error event
  input  wire logic [7:0]             logdir_addr,    // log directory byte
  output logic                        preserve_en,    // identify enable bit
  output settings_pkg::settings_t     settings,       // current settings
  output logic [7:0]                  rd_err_cnt,     // read stream error log
  output logic [7:0]                  wr_err_cnt,     // write stream error log
  output logic [7:0]                  logdir_data     // log directory value
);
  import settings_pkg::*;

  logic      preserve_reg, preserve_next;
  settings_t set_reg, set_next;
  logic [7:0] rd_err_reg, rd_err_next, wr_err_reg, wr_err_next, logdir_reg, logdir_next;

  // log directory lookup
  function automatic logic [7:0] logdir_value(input logic [7:0] addr);
    logic [7:0] v;
    v = LOGDIR_ABSENT;
    if (addr == LOGDIR_QUEUE_LO && HAS_QUEUE_LOG) v = LOGDIR_PRESENT;
    if (addr == LOGDIR_EVENT_LO && HAS_EVENT_LOG) v = LOGDIR_PRESENT;
    return v;
  endfunction : logdir_value

  // preservation flag next value
  always_comb begin
    preserve_next = preserve_reg;
    if (link_reset) begin
      preserve_next = HAS_PRESERVE;
    end else if (soft_reset) begin
      preserve_next = preserve_reg;
    end else if (cmd_valid && cmd.kind == CMD_SET_FEATURES && cmd.count == SATA_SEL_PRESERVE && HAS_PRESERVE) begin
      if (cmd.feature == FEAT_SATA_EN) preserve_next = 1'b1;
      else if (cmd.feature == FEAT_SATA_DIS) preserve_next = 1'b0;
    end
  end

  // settings next value
  always_comb begin
    set_next    = set_reg;
    rd_err_next = rd_err_reg;
    wr_err_next = wr_err_reg;
    logdir_next = logdir_value(logdir_addr);
    if (link_reset && !preserve_reg) begin
      set_next    = SETTINGS_DEFAULT;
      rd_err_next = 8'h00;
      wr_err_next = 8'h00;
    end else if (link_reset) begin
      set_next = set_reg;
    end else begin
      if (HAS_STREAM && rd_err_log && rd_err_reg != 8'hFF) rd_err_next = rd_err_reg + 8'h01;
      if (HAS_STREAM && wr_err_log && wr_err_reg != 8'hFF) wr_err_next = wr_err_reg + 8'h01;
      if (cmd_valid) begin
        unique case (cmd.kind)
          CMD_SET_FEATURES: begin
            unique case (cmd.feature)
              FEAT_WCACHE_EN:  set_next.wcache_en = 1'b1;
              FEAT_WCACHE_DIS: set_next.wcache_en = 1'b0;
              FEAT_XFER_MODE:  set_next.xfer_mode = cmd.count;
              FEAT_APM_EN: if (HAS_APM) begin
                set_next.apm_en    = 1'b1;
                set_next.apm_level = cmd.count;
              end
              FEAT_APM_DIS: if (HAS_APM) set_next.apm_en = 1'b0;
              FEAT_RLA_EN:     set_next.rla_en    = 1'b1;
              FEAT_RLA_DIS:    set_next.rla_en    = 1'b0;
              FEAT_RELINT_EN:  set_next.relint_en = 1'b1;
              FEAT_RELINT_DIS: set_next.relint_en = 1'b0;
              FEAT_SVCINT_EN:  set_next.svcint_en = 1'b1;
              FEAT_SVCINT_DIS: set_next.svcint_en = 1'b0;
              FEAT_REVERT_EN:  set_next.revert_en = 1'b1;
              FEAT_REVERT_DIS: set_next.revert_en = 1'b0;
              default: ;
            endcase
          end
          CMD_INIT_PARAMS:  set_next.geometry      = cmd.data[15:0];
          CMD_STANDBY:      set_next.standby_timer = cmd.data[7:0];
          CMD_SET_MAX:      set_next.max_lba       = cmd.data;
          CMD_SET_MULTIPLE: set_next.multiple_size = cmd.data[7:0];
          CMD_SEC_STATE: if (HAS_SECURITY) set_next.sec_state = sec_state_t'(cmd.data[1:0]);
          CMD_UNLOCK_FAIL: if (HAS_SECURITY && set_reg.unlock_cnt != 3'h0)
            set_next.unlock_cnt = set_reg.unlock_cnt - 3'h1;
          CMD_FREEZE: if (HAS_SECURITY) set_next.frozen = 1'b1;
          default: ;
        endcase
      end
    end
  end

  // registers; power-up restores defaults
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      preserve_reg <= HAS_PRESERVE;
      set_reg      <= SETTINGS_DEFAULT;
      rd_err_reg   <= 8'h00;
      wr_err_reg   <= 8'h00;
      logdir_reg   <= 8'h00;
    end else begin
      preserve_reg <= preserve_next;
      set_reg      <= set_next;
      rd_err_reg   <= rd_err_next;
      wr_err_reg   <= wr_err_next;
      logdir_reg   <= logdir_next;
    end
  end

  assign preserve_en = preserve_reg;
  assign settings    = set_reg;
  assign rd_err_cnt  = rd_err_reg;
  assign wr_err_cnt  = wr_err_reg;
  assign logdir_data = logdir_reg;

endmodule : settings_preserve

// File: core/settings_pkg.sv
package settings_pkg;

  // feature command codes
  localparam logic [7:0] FEAT_SATA_EN      = 8'h10;
  localparam logic [7:0] FEAT_SATA_DIS     = 8'h90;
  localparam logic [7:0] SATA_SEL_PRESERVE = 8'h06;
  localparam logic [7:0] FEAT_WCACHE_EN    = 8'h02;
  localparam logic [7:0] FEAT_WCACHE_DIS   = 8'h82;
  localparam logic [7:0] FEAT_XFER_MODE    = 8'h03;
  localparam logic [7:0] FEAT_APM_EN       = 8'h05;
  localparam logic [7:0] FEAT_APM_DIS      = 8'h85;
  localparam logic [7:0] FEAT_RLA_EN       = 8'hAA;
  localparam logic [7:0] FEAT_RLA_DIS      = 8'h55;
  localparam logic [7:0] FEAT_RELINT_EN    = 8'h5D;
  localparam logic [7:0] FEAT_RELINT_DIS   = 8'hDD;
  localparam logic [7:0] FEAT_SVCINT_EN    = 8'h5E;
  localparam logic [7:0] FEAT_SVCINT_DIS   = 8'hDE;
  localparam logic [7:0] FEAT_REVERT_EN    = 8'hCC;
  localparam logic [7:0] FEAT_REVERT_DIS   = 8'h66;

  // log directory offsets and values
  localparam logic [7:0] LOGDIR_QUEUE_LO   = 8'h20;
  localparam logic [7:0] LOGDIR_QUEUE_HI   = 8'h21;
  localparam logic [7:0] LOGDIR_EVENT_LO   = 8'h22;
  localparam logic [7:0] LOGDIR_EVENT_HI   = 8'h23;
  localparam logic [7:0] LOGDIR_PRESENT    = 8'h01;
  localparam logic [7:0] LOGDIR_ABSENT     = 8'h00;

  // security states
  typedef enum logic [1:0] {
    SEC_DISABLED              = 2'h0,
    unlocked_not_frozen_state = 2'h1,
    enabled_locked_state      = 2'h3,
    SEC_FROZEN                = 2'h2
  } sec_state_t;

  // host command kinds
  typedef enum logic [2:0] {
    CMD_SET_FEATURES = 3'h0,
    CMD_INIT_PARAMS  = 3'h1,
    CMD_STANDBY      = 3'h2,
    CMD_SET_MAX      = 3'h3,
    CMD_SET_MULTIPLE = 3'h4,
    CMD_SEC_STATE    = 3'h5,
    CMD_UNLOCK_FAIL  = 3'h6,
    CMD_FREEZE       = 3'h7
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t  kind;
    logic [7:0] feature;
    logic [7:0] count;
    logic [47:0] data;
  } host_cmd_t;

  // preserved settings
  typedef struct packed {
    logic [15:0] geometry;
    logic [7:0]  standby_timer;
    logic [47:0] max_lba;
    logic [7:0]  multiple_size;
    logic [7:0]  xfer_mode;
    logic [7:0]  apm_level;
    logic        apm_en;
    logic        wcache_en;
    logic        rla_en;
    logic        relint_en;
    logic        svcint_en;
    logic        revert_en;
    sec_state_t  sec_state;
    logic        frozen;
    logic [2:0]  unlock_cnt;
  } settings_t;

  localparam logic [2:0]  UNLOCK_CNT_INIT = 3'h5;
  localparam logic [47:0] MAX_LBA_INIT    = 48'hFFFFFFFFFFFF;

  localparam settings_t SETTINGS_DEFAULT = '{
    geometry: 16'h0000, standby_timer: 8'h00, max_lba: MAX_LBA_INIT,
    multiple_size: 8'h00, xfer_mode: 8'h00, apm_level: 8'h00, apm_en: 1'b0,
    wcache_en: 1'b1, rla_en: 1'b1, relint_en: 1'b0, svcint_en: 1'b0,
    revert_en: 1'b0, sec_state: SEC_DISABLED, frozen: 1'b0,
    unlock_cnt: UNLOCK_CNT_INIT};

endpackage : settings_pkg

// File: sim/settings_preserve_sva.sv
`timescale 1ns/1ps
module settings_preserve_sva
  import settings_pkg::*;
(
  input wire logic                    clk_sys,     // clock
  input wire logic                    rst,         // reset
  input wire logic                    soft_reset,  // soft reset
  input wire logic                    link_reset,  // link reset
  input wire logic                    cmd_valid,   // strobe
  input wire settings_pkg::host_cmd_t cmd,         // command
  input wire logic [7:0]              logdir_addr, // log byte
  input wire logic                    preserve_en, // flag
  input wire settings_pkg::settings_t settings,    // settings
  input wire logic [7:0]              rd_err_cnt,  // read log
  input wire logic [7:0]              logdir_data  // log value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // preservation subcommand issued this cycle outside a link reset
  wire sel = cmd_valid && !link_reset && cmd.kind == CMD_SET_FEATURES && cmd.count == SATA_SEL_PRESERVE;
  reset_dflt_a: assert property ($fell(rst) |-> preserve_en && settings == SETTINGS_DEFAULT)
    else $error("bad reset state");
  flag_off_a: assert property (sel && cmd.feature == FEAT_SATA_DIS |=> !preserve_en)
    else $error("flag not cleared");
  link_flag_a: assert property (link_reset |=> preserve_en)
    else $error("flag not restored");
  soft_keep_a: assert property (soft_reset && !link_reset && !cmd_valid |=> $stable(preserve_en))
    else $error("flag moved");
  link_keep_a: assert property (link_reset && preserve_en |=> settings == $past(settings)
    && rd_err_cnt == $past(rd_err_cnt)) else $error("settings lost");
  link_clear_a: assert property (link_reset && !preserve_en |=> settings == SETTINGS_DEFAULT)
    else $error("settings kept");
  queue_dir_a: assert property (logdir_addr == LOGDIR_QUEUE_LO |=> logdir_data == LOGDIR_PRESENT)
    else $error("queue entry wrong");
  event_dir_a: assert property (logdir_addr == LOGDIR_EVENT_LO |=> logdir_data == LOGDIR_PRESENT)
    else $error("event entry wrong");
  // main scenarios
  cover property (link_reset && preserve_en);
  cover property (link_reset && !preserve_en);
  cover property (sel && cmd.feature == FEAT_SATA_DIS);
endmodule : settings_preserve_sva

// File: sim/host_model.sv
`timescale 1ns/1ps
module host_model
  import settings_pkg::*;
(
  input  wire logic           clk_sys,  // clock
  output settings_pkg::host_cmd_t cmd,  // command
  output logic                cmd_valid // strobe
);
  // one command of any kind, then an idle cycle with scrambled fields
  task automatic send_cmd(input cmd_kind_t k, input logic [7:0] f, input logic [7:0] c, input logic [47:0] d);
    cmd_valid = 1'b1;
    cmd = '{k, f, c, d};
    @(posedge clk_sys);
    #2;
    cmd_valid = 1'b0;
    cmd = ~cmd;
    @(posedge clk_sys);
    #2;
  endtask : send_cmd
  // one feature command
  task automatic send(input logic [7:0] f, input logic [7:0] c);
    send_cmd(CMD_SET_FEATURES, f, c, 48'h0);
  endtask : send
  // idle at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
endmodule : host_model

// File: sim/settings_preserve_bench.sv
`timescale 1ns/1ps
module settings_preserve_bench;
  import settings_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, soft_reset = 1'b0, link_reset = 1'b0, rd_err_log = 1'b0, wr_err_log = 1'b0;
  logic [7:0] wr_exp = 8'h00;
  logic [47:0] d;
  logic preserve_en, cmd_valid;
  logic [7:0] logdir_addr = 8'h00, rd_err_cnt, wr_err_cnt, logdir_data, f, c, rd_exp = 8'h00;
  host_cmd_t cmd;
  settings_t settings, exp;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  localparam logic [7:0] FEATS [13] = '{FEAT_WCACHE_EN, FEAT_WCACHE_DIS, FEAT_XFER_MODE, FEAT_APM_EN,
    FEAT_APM_DIS, FEAT_RLA_EN, FEAT_RLA_DIS, FEAT_RELINT_EN, FEAT_RELINT_DIS, FEAT_SVCINT_EN,
    FEAT_SVCINT_DIS, FEAT_REVERT_EN, FEAT_REVERT_DIS};
  host_model host (.clk_sys, .cmd, .cmd_valid);
  settings_preserve uut (.clk_sys, .rst, .soft_reset, .link_reset, .cmd_valid, .cmd, .rd_err_log,
    .wr_err_log, .logdir_addr, .preserve_en, .settings, .rd_err_cnt, .wr_err_cnt, .logdir_data);
  // expected settings after one feature command
  function automatic settings_t apply(settings_t s, logic [7:0] f, logic [7:0] c);
    case (f)
      FEAT_WCACHE_EN: s.wcache_en = 1'b1;
      FEAT_WCACHE_DIS: s.wcache_en = 1'b0;
      FEAT_XFER_MODE: s.xfer_mode = c;
      FEAT_APM_EN: {s.apm_en, s.apm_level} = {1'b1, c};
      FEAT_APM_DIS: s.apm_en = 1'b0;
      FEAT_RLA_EN: s.rla_en = 1'b1;
      FEAT_RLA_DIS: s.rla_en = 1'b0;
      FEAT_RELINT_EN: s.relint_en = 1'b1;
      FEAT_RELINT_DIS: s.relint_en = 1'b0;
      FEAT_SVCINT_EN: s.svcint_en = 1'b1;
      FEAT_SVCINT_DIS: s.svcint_en = 1'b0;
      FEAT_REVERT_EN: s.revert_en = 1'b1;
      default: s.revert_en = 1'b0;
    endcase
    return s;
  endfunction : apply
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : step
  task automatic chk_s(input settings_t a, input settings_t e);
    cmp_count++;
    if (a !== e) begin
      miscompares++;
      $display("ERROR %0t settings differ", $time);
    end
  endtask : chk_s
  task automatic chk_b(input logic [7:0] a, input logic [7:0] e);
    cmp_count++;
    if (a !== e) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, a, e);
    end
  endtask : chk_b
  // one-cycle soft or link reset pulse
  task automatic pulse(input bit lk);
    if (lk) link_reset = 1'b1;
    else soft_reset = 1'b1;
    step();
    {link_reset, soft_reset} = 2'b00;
    step();
  endtask : pulse
  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial forever #25 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) if (++cycles == 1000) begin
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(60));
    step(6);
    rst = 1'b0;
    exp = SETTINGS_DEFAULT;
    chk_s(settings, exp);
    chk_b({7'h00, preserve_en}, 8'h01);
    for (int i = 0; i < 40; i++) begin
      f = (i < 13) ? FEATS[i] : FEATS[$urandom_range(12)];
      c = 8'($urandom);
      host.send(f, c);
      exp = apply(exp, f, c);
      rd_err_log = 1'($urandom_range(1));
      rd_exp += rd_err_log;
      wr_err_log = 1'($urandom_range(1));
      wr_exp += wr_err_log;
      step();
      rd_err_log = 1'b0;
      wr_err_log = 1'b0;
    end
    // every non-feature command kind once, random payload
    for (int k = 1; k < 8; k++) begin
      d = {16'($urandom), 32'($urandom)};
      host.send_cmd(cmd_kind_t'(k), 8'h00, 8'h00, d);
      case (cmd_kind_t'(k))
        CMD_INIT_PARAMS: exp.geometry = d[15:0];
        CMD_STANDBY: exp.standby_timer = d[7:0];
        CMD_SET_MAX: exp.max_lba = d;
        CMD_SET_MULTIPLE: exp.multiple_size = d[7:0];
        CMD_SEC_STATE: exp.sec_state = sec_state_t'(d[1:0]);
        CMD_UNLOCK_FAIL: exp.unlock_cnt = UNLOCK_CNT_INIT - 3'h1;
        default: exp.frozen = 1'b1;
      endcase
    end
    chk_s(settings, exp);
    pulse(0);
    chk_b({7'h00, preserve_en}, 8'h01);
    pulse(1);
    chk_s(settings, exp);
    chk_b(rd_err_cnt, rd_exp);
    chk_b(wr_err_cnt, wr_exp);
    host.send(FEAT_SATA_DIS, SATA_SEL_PRESERVE);
    chk_b({7'h00, preserve_en}, 8'h00);
    pulse(0);
    chk_b({7'h00, preserve_en}, 8'h00);
    pulse(1);
    chk_s(settings, SETTINGS_DEFAULT);
    chk_b(rd_err_cnt, 8'h00);
    chk_b(wr_err_cnt, 8'h00);
    chk_b({7'h00, preserve_en}, 8'h01);
    for (int i = 0; i < 12; i++) begin
      logdir_addr = (i < 4) ? 8'(8'h20 + i) : 8'($urandom_range(8'h2F, 8'h10));
      step();
      chk_b(logdir_data, (logdir_addr == 8'h20 || logdir_addr == 8'h22) ? 8'h01 : 8'h00);
    end
    summarize();
  end
endmodule : settings_preserve_bench

bind settings_preserve settings_preserve_sva sva (.clk_sys, .rst, .soft_reset, .link_reset, .cmd_valid,
  .cmd, .logdir_addr, .preserve_en, .settings, .rd_err_cnt, .logdir_data);
